/* dv/ifc_line_ctrl_assertions.sv */
// Checker of bus handshake and status read behaviour
`timescale 1ns/1ps
`default_nettype none
`include "ifc_map.svh"
module ifc_line_ctrl_assertions #(
  parameter int LINES = 32,
  parameter int EXT   = 8
) (
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [11:0]      paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic [LINES-1:0] line_n,
  input wire logic             fast_request_line_n,
  input wire logic [EXT-1:0]   external_line,
  input wire logic [EXT-1:0]   external_line_edge,
  input wire logic             irq_req,
  input wire logic             fiq_req,
  input wire logic             evt_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire logic rd_done;
  assign rd_done = pready && psel && penable && !pwrite;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  a_ready_access: assert property (s_setup |=> s_access) else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready) else $error("ready held too long");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_idle_zero: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
  a_flag_onehot: assert property (rd_done && paddr == `IFC_OFS_LINE_FLAG |-> $onehot0(prdata))
    else $error("flag word not one-hot");
  a_num_idle: assert property (rd_done && paddr == `IFC_OFS_LINE_NUM && prdata[8]
    |-> prdata[4:0] == 5'h00) else $error("line number not zero when idle");
  a_wo_zero: assert property (rd_done && (paddr == `IFC_OFS_LINE_DONE
    || paddr == `IFC_OFS_FAST_DONE || paddr == `IFC_OFS_NUM_DONE) |-> prdata == 32'h0)
    else $error("write-only word reads non-zero");
  a_ext_width: assert property (rd_done && paddr == `IFC_OFS_EXT_STATUS |-> prdata[31:8] == 24'h0)
    else $error("external status upper bits set");
  a_reset_quiet: assert property ($rose(rst_n) |-> (!irq_req && !fiq_req)[*2])
    else $error("request out right after reset");
endmodule
bind ifc_line_ctrl ifc_line_ctrl_assertions #(.LINES(LINES), .EXT(EXT)) u_chk (.clk(clk),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_n(line_n),
  .fast_request_line_n(fast_request_line_n), .external_line(external_line),
  .external_line_edge(external_line_edge), .irq_req(irq_req), .fiq_req(fiq_req),
  .evt_irq(evt_irq));
`default_nettype wire

/* dv/ifc_src_model.sv */
// Peripheral request source model
`timescale 1ns/1ps
`default_nettype none
module ifc_src_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [31:0] want_line,
  input  wire logic        want_fast,
  input  wire logic [7:0]  want_ext,
  output logic      [31:0] line_n,
  output logic             fast_n,
  output logic      [7:0]  ext_line
);
  // Active-low lines idle high, change just after an edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_n   <= 32'hFFFFFFFF;
      fast_n   <= 1'b1;
      ext_line <= 8'h00;
    end else begin
      line_n   <= ~want_line;
      fast_n   <= ~want_fast;
      ext_line <= want_ext;
    end
  end
endmodule
`default_nettype wire

/* dv/irq_fiq_line_controller_tb.sv */
// Self-checking bench of the line controller
`timescale 1ns/1ps
`default_nettype none
`include "ifc_map.svh"
module irq_fiq_line_controller_tb;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata, want_line, line_n;
  logic        want_fast, fast_n, irq_req, fiq_req, evt_irq;
  logic [7:0]  want_ext, ext_line, ext_edge;
  int          mismatches, compares, a, b, c, d, e;
  logic [11:0] rst_addr [7] = '{`IFC_OFS_LINE_TRIG, `IFC_OFS_SW_RAISE, `IFC_OFS_FAST_CTRL,
                                `IFC_OFS_LINE_NUM, `IFC_OFS_EXT_STATUS, `IFC_OFS_LINE_MASK,
                                `IFC_OFS_LINE_DONE};
  logic [31:0] rst_val [7] = '{32'h0, 32'h0, 32'h1, 32'h100, 32'h0, 32'hFFFFFFFF, 32'h0};
  ifc_src_model src (.clk(clk), .rst_n(rst_n), .want_line(want_line), .want_fast(want_fast),
    .want_ext(want_ext), .line_n(line_n), .fast_n(fast_n), .ext_line(ext_line));
  ifc_line_ctrl dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_n(line_n), .fast_request_line_n(fast_n),
    .external_line(ext_line), .external_line_edge(ext_edge), .irq_req(irq_req),
    .fiq_req(fiq_req), .evt_irq(evt_irq));
  function automatic logic [31:0] exp_num(input logic v, input int n);
    return v ? 32'(n) : 32'h00000100;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] adr, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= adr;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rdata = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle;
    repeat (4) @(posedge clk);
  endtask
  task automatic final_report;
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    final_report;
  end
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, want_fast, want_ext, ext_edge} = '0;
    {want_line, mismatches, compares} = '0;
    void'($urandom(92641));
    a = $urandom_range(30, 0);
    b = $urandom_range(31, a + 1);
    c = $urandom_range(31, 0);
    d = $urandom_range(31, 0);
    e = $urandom_range(7, 0);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, rst_addr[i], 32'h0);
      chk(rdata, rst_val[i]);
    end
    apb(1'b0, 12'h300, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    apb(1'b1, `IFC_OFS_LINE_FLAG, 32'hFFFFFFFF);
    apb(1'b0, `IFC_OFS_LINE_FLAG, 32'h0);
    chk(rdata, 32'h0);
    $display("test reset done");
    apb(1'b1, `IFC_OFS_LINE_MASK, 32'h0);
    want_line <= (32'h1 << a) | (32'h1 << b);
    settle;
    chk({31'h0, irq_req}, 32'h1);
    apb(1'b0, `IFC_OFS_LINE_FLAG, 32'h0);
    chk(rdata, 32'h1 << a);
    apb(1'b1, `IFC_OFS_NUM_DONE, 32'(a));
    settle;
    apb(1'b0, `IFC_OFS_LINE_NUM, 32'h0);
    chk(rdata, exp_num(1'b1, b));
    apb(1'b1, `IFC_OFS_LINE_DONE, 32'h1 << b);
    settle;
    apb(1'b0, `IFC_OFS_LINE_NUM, 32'h0);
    chk(rdata, exp_num(1'b0, 0));
    chk({31'h0, irq_req}, 32'h0);
    want_line <= 32'h0;
    $display("test edge done");
    apb(1'b1, `IFC_OFS_LINE_TRIG, 32'h1 << c);
    want_line <= 32'h1 << c;
    settle;
    apb(1'b0, `IFC_OFS_LINE_NUM, 32'h0);
    chk(rdata, exp_num(1'b1, c));
    apb(1'b1, `IFC_OFS_LINE_DONE, 32'h1 << c);
    settle;
    apb(1'b0, `IFC_OFS_LINE_NUM, 32'h0);
    chk(rdata, exp_num(1'b1, c));
    want_line <= 32'h0;
    apb(1'b1, `IFC_OFS_LINE_DONE, 32'h1 << c);
    settle;
    apb(1'b0, `IFC_OFS_LINE_NUM, 32'h0);
    chk(rdata, exp_num(1'b0, 0));
    apb(1'b1, `IFC_OFS_LINE_TRIG, 32'h0);
    $display("test level done");
    apb(1'b1, `IFC_OFS_EVT_STATUS, 32'h7);
    apb(1'b1, `IFC_OFS_LINE_MASK, 32'hFFFFFFFF);
    apb(1'b1, `IFC_OFS_SW_RAISE, 32'h1 << d);
    settle;
    chk({31'h0, irq_req}, 32'h0);
    apb(1'b1, `IFC_OFS_LINE_MASK, ~(32'h1 << d));
    settle;
    chk({irq_req, evt_irq}, 32'h2);
    apb(1'b1, `IFC_OFS_EVT_MASK, 32'h1);
    settle;
    chk({31'h0, evt_irq}, 32'h1);
    apb(1'b1, `IFC_OFS_SW_RAISE, 32'h0);
    apb(1'b1, `IFC_OFS_LINE_DONE, 32'h1 << d);
    settle;
    chk({31'h0, irq_req}, 32'h0);
    apb(1'b1, `IFC_OFS_EVT_STATUS, 32'h1);
    settle;
    chk({31'h0, evt_irq}, 32'h0);
    $display("test raise done");
    apb(1'b1, `IFC_OFS_FAST_CTRL, 32'h0);
    want_fast <= 1'b1;
    settle;
    chk({31'h0, fiq_req}, 32'h1);
    apb(1'b1, `IFC_OFS_FAST_DONE, 32'h1);
    settle;
    chk({31'h0, fiq_req}, 32'h0);
    want_fast <= 1'b0;
    $display("test fast done");
    ext_edge <= 8'h1 << e;
    want_ext <= 8'h1 << e;
    settle;
    want_ext <= 8'h0;
    settle;
    apb(1'b0, `IFC_OFS_EXT_STATUS, 32'h0);
    chk(rdata, 32'h1 << e);
    apb(1'b0, `IFC_OFS_EXT_STATUS, 32'h0);
    chk(rdata, 32'h0);
    $display("test external done");
    final_report;
  end
endmodule
`default_nettype wire

/* include/ifc_map.svh */
// Register offsets, field positions and reset values of the line controller
`ifndef IFC_MAP_SVH
`define IFC_MAP_SVH
`define IFC_OFS_LINE_MASK      12'h01C
`define IFC_OFS_LINE_FLAG      12'h028
`define IFC_OFS_LINE_DONE      12'h02C
`define IFC_OFS_LINE_TRIG      12'h030
`define IFC_OFS_SW_RAISE       12'h034
`define IFC_OFS_FAST_CTRL      12'h038
`define IFC_OFS_FAST_DONE      12'h03C
`define IFC_OFS_LINE_NUM       12'h040
`define IFC_OFS_NUM_DONE       12'h044
`define IFC_OFS_EXT_STATUS     12'h100
`define IFC_OFS_EVT_STATUS     12'h200
`define IFC_OFS_EVT_MASK       12'h204
`define IFC_MASK_RESET         32'hFFFFFFFF
`define IFC_FAST_MASK_BIT      0
`define IFC_FAST_TRIG_BIT      1
`define IFC_FAST_CTRL_RESET    2'h1
`define IFC_NO_REQ_BIT         8
`define IFC_EVT_LINE_BIT       0
`define IFC_EVT_FAST_BIT       1
`define IFC_EVT_EXT_BIT        2
`endif

/* include/ifc_pkg.sv */
// Types shared by the line controller
package ifc_pkg;
  typedef enum logic [1:0] {
    IFC_ACC_IDLE   = 2'b00,
    IFC_ACC_ACCESS = 2'b01
  } ifc_acc_type;
endpackage

/* logic/ifc_line_ctrl.sv */
// Prioritised normal/fast request line controller with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "ifc_map.svh"

module ifc_line_ctrl #(
  parameter int LINES = 32,
  parameter int EXT   = 8
) (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [LINES-1:0] line_n,
  input  wire logic            fast_request_line_n,
  input  wire logic [EXT-1:0]  external_line,
  input  wire logic [EXT-1:0]  external_line_edge,
  output logic                 irq_req,
  output logic                 fiq_req,
  output logic                 evt_irq
);

  // Refuse line counts the status views cannot carry
  if (LINES != 32 || EXT < 1 || EXT > 8) begin : gen_bad_cfg
    $error("Unsupported line counts");
  end

  // ==========================================================
  // APB access
  // ==========================================================
  ifc_pkg::ifc_acc_type acc_ff;
  logic                 wr_stb;
  logic                 rd_stb;

  // Every access answered in its first access cycle
  assign wr_stb = psel & penable & pwrite & pready;
  assign rd_stb = psel & penable & ~pwrite & pready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff <= ifc_pkg::IFC_ACC_IDLE;
    end else begin
      unique case (acc_ff)
        ifc_pkg::IFC_ACC_IDLE: begin
          if (psel && !penable) begin
            acc_ff <= ifc_pkg::IFC_ACC_ACCESS;
          end
        end
        ifc_pkg::IFC_ACC_ACCESS: begin
          acc_ff <= ifc_pkg::IFC_ACC_IDLE;
        end
        default: begin
          acc_ff <= ifc_pkg::IFC_ACC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & ~penable;
    end
  end

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic known(input logic [11:0] a);
    known = hit(a, `IFC_OFS_LINE_MASK) | hit(a, `IFC_OFS_LINE_FLAG)
          | hit(a, `IFC_OFS_LINE_DONE) | hit(a, `IFC_OFS_LINE_TRIG)
          | hit(a, `IFC_OFS_SW_RAISE) | hit(a, `IFC_OFS_FAST_CTRL)
          | hit(a, `IFC_OFS_FAST_DONE) | hit(a, `IFC_OFS_LINE_NUM)
          | hit(a, `IFC_OFS_NUM_DONE) | hit(a, `IFC_OFS_EXT_STATUS)
          | hit(a, `IFC_OFS_EVT_STATUS) | hit(a, `IFC_OFS_EVT_MASK);
  endfunction

  // ==========================================================
  // Configuration registers
  // ==========================================================
  logic [LINES-1:0] mask_ff;
  logic [LINES-1:0] trig_ff;
  logic [LINES-1:0] raise_ff;
  logic [1:0]       fast_ctrl_ff;
  logic [2:0]       evt_mask_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_ff <= `IFC_MASK_RESET;
    end else if (wr_stb && hit(paddr, `IFC_OFS_LINE_MASK)) begin
      mask_ff <= pwdata[LINES-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_ff <= '0;
    end else if (wr_stb && hit(paddr, `IFC_OFS_LINE_TRIG)) begin
      trig_ff <= pwdata[LINES-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      raise_ff <= '0;
    end else if (wr_stb && hit(paddr, `IFC_OFS_SW_RAISE)) begin
      raise_ff <= pwdata[LINES-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_ctrl_ff <= `IFC_FAST_CTRL_RESET;
    end else if (wr_stb && hit(paddr, `IFC_OFS_FAST_CTRL)) begin
      fast_ctrl_ff <= pwdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_mask_ff <= '0;
    end else if (wr_stb && hit(paddr, `IFC_OFS_EVT_MASK)) begin
      evt_mask_ff <= pwdata[2:0];
    end
  end

  // ==========================================================
  // Completion commands
  // ==========================================================
  logic [LINES-1:0] done_vec;
  logic             fast_done;
  logic             flag_rd;

  always_comb begin
    done_vec = '0;
    if (wr_stb && hit(paddr, `IFC_OFS_LINE_DONE)) begin
      done_vec = pwdata[LINES-1:0];
    end
    if (wr_stb && hit(paddr, `IFC_OFS_NUM_DONE)) begin
      done_vec[pwdata[4:0]] = 1'b1;
    end
  end

  assign fast_done = wr_stb & hit(paddr, `IFC_OFS_FAST_DONE) & pwdata[0];
  // Both status views clear alike
  assign flag_rd = rd_stb & (hit(paddr, `IFC_OFS_LINE_FLAG)
                 | hit(paddr, `IFC_OFS_LINE_NUM));

  // ==========================================================
  // Per-line trigger and service state
  // ==========================================================
  logic [LINES-1:0] prev_ff;
  logic [LINES-1:0] pend_ff;
  logic [LINES-1:0] busy_ff;
  logic [LINES-1:0] req_vec;
  logic [LINES-1:0] flag_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff <= '1;
    end else begin
      prev_ff <= line_n;
    end
  end

  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : gen_line
      logic fall;
      logic trig;
      assign fall = prev_ff[g] & ~line_n[g];
      // Level lines request whenever low and not in service
      assign trig = (trig_ff[g] ? ~line_n[g] : fall) | raise_ff[g];

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pend_ff[g] <= 1'b0;
        end else if (trig && !busy_ff[g]) begin
          pend_ff[g] <= 1'b1;
        end else if (done_vec[g]) begin
          pend_ff[g] <= 1'b0;
        end
      end

      // Edge lines taken once pending, level lines once flagged and read; held until completion
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          busy_ff[g] <= 1'b0;
        end else if (done_vec[g]) begin
          busy_ff[g] <= 1'b0;
        end else if (pend_ff[g] && !trig_ff[g]) begin
          busy_ff[g] <= 1'b1;
        end else if (flag_rd && flag_ff[g]) begin
          busy_ff[g] <= 1'b1;
        end
      end

      assign req_vec[g] = pend_ff[g] & ~mask_ff[g];
    end
  endgenerate

  // ==========================================================
  // Priority and status views
  // ==========================================================
  logic [LINES-1:0] nxt_flag;
  logic [4:0]       num_ff;
  logic [4:0]       nxt_num;
  logic             none_ff;
  logic             flag_held_ff;

  always_comb begin
    nxt_flag = '0;
    nxt_num  = '0;
    for (int i = LINES - 1; i >= 0; i--) begin
      // A line being completed this cycle must not be flagged again
      if (req_vec[i] && !done_vec[i] && !(busy_ff[i] && trig_ff[i])) begin
        nxt_flag = '0;
        nxt_flag[i] = 1'b1;
        nxt_num = 5'(i);
      end
    end
  end

  // Snapshot holds until read or its line completes, so a read sees a stable one-hot word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff      <= '0;
      num_ff       <= '0;
      none_ff      <= 1'b1;
      flag_held_ff <= 1'b0;
    end else if (flag_rd) begin
      flag_ff      <= '0;
      num_ff       <= '0;
      none_ff      <= 1'b1;
      flag_held_ff <= 1'b0;
    end else if (!flag_held_ff || (flag_ff & done_vec) != '0) begin
      flag_ff      <= nxt_flag;
      num_ff       <= nxt_num;
      none_ff      <= (nxt_flag == '0);
      flag_held_ff <= (nxt_flag != '0);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= |req_vec;
    end
  end

  // ==========================================================
  // Fast request line
  // ==========================================================
  logic fprev_ff;
  logic fpend_ff;
  logic ftrig;

  assign ftrig = fast_ctrl_ff[`IFC_FAST_TRIG_BIT] ? ~fast_request_line_n
               : (fprev_ff & ~fast_request_line_n);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fprev_ff <= 1'b1;
    end else begin
      fprev_ff <= fast_request_line_n;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fpend_ff <= 1'b0;
    end else if (ftrig) begin
      fpend_ff <= 1'b1;
    end else if (fast_done) begin
      fpend_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fiq_req <= 1'b0;
    end else begin
      fiq_req <= fpend_ff & ~fast_ctrl_ff[`IFC_FAST_MASK_BIT];
    end
  end

  // ==========================================================
  // External line status
  // ==========================================================
  logic [EXT-1:0] ext_ff;
  logic           ext_rd;

  assign ext_rd = rd_stb & hit(paddr, `IFC_OFS_EXT_STATUS);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_ff <= '0;
    end else begin
      // Edge sources drop on read, new arrivals win
      ext_ff <= external_line
              | (ext_ff & ~(external_line_edge & {EXT{ext_rd}}));
    end
  end

  // ==========================================================
  // Event status and interrupt
  // ==========================================================
  logic [2:0] evt_ff;
  logic [2:0] evt_set;
  logic [2:0] evt_clr;

  assign evt_set = {|ext_ff, fiq_req, irq_req};
  assign evt_clr = (wr_stb && hit(paddr, `IFC_OFS_EVT_STATUS)) ? pwdata[2:0] : 3'h0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_ff <= '0;
    end else begin
      evt_ff <= evt_set | (evt_ff & ~evt_clr);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_irq <= 1'b0;
    end else begin
      evt_irq <= |((evt_set | (evt_ff & ~evt_clr)) & evt_mask_ff);
    end
  end

  // ==========================================================
  // Read data
  // ==========================================================
  logic [31:0] rdata;

  always_comb begin
    rdata = '0;
    if (hit(paddr, `IFC_OFS_LINE_MASK)) rdata[LINES-1:0] = mask_ff;
    if (hit(paddr, `IFC_OFS_LINE_FLAG)) rdata[LINES-1:0] = flag_ff;
    if (hit(paddr, `IFC_OFS_LINE_TRIG)) rdata[LINES-1:0] = trig_ff;
    if (hit(paddr, `IFC_OFS_SW_RAISE))  rdata[LINES-1:0] = raise_ff;
    if (hit(paddr, `IFC_OFS_FAST_CTRL)) rdata[1:0] = fast_ctrl_ff;
    if (hit(paddr, `IFC_OFS_LINE_NUM)) begin
      rdata[4:0] = num_ff;
      rdata[`IFC_NO_REQ_BIT] = none_ff;
    end
    if (hit(paddr, `IFC_OFS_EXT_STATUS)) rdata[EXT-1:0] = ext_ff;
    if (hit(paddr, `IFC_OFS_EVT_STATUS)) rdata[2:0] = evt_ff;
    if (hit(paddr, `IFC_OFS_EVT_MASK))   rdata[2:0] = evt_mask_ff;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= (psel && !penable && !pwrite) ? rdata : 32'h0;
      pslverr <= psel & ~penable & ~known(paddr);
    end
  end

endmodule
`default_nettype wire
